// File: design/acs_map.vh
// acs_map.vh: register map, field positions, reset values and divider counts
// for the async serial channel; included by the channel design file.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
// word indices; byte address is four times the index
`define ACS_CTRL_A 3'h0
`define ACS_CTRL_B 3'h1
`define ACS_STATUS 3'h2
`define ACS_TX_HOLD 3'h3
`define ACS_RX_DATA 3'h4
`define ACS_EXT 3'h5
// control a fields
`define ACS_A_WAKE 7
`define ACS_A_RXON 6
`define ACS_A_TXON 5
`define ACS_A_RTS 4
`define ACS_A_ADDR 3
// control b fields
`define ACS_B_TXADDR 7
`define ACS_B_MDROP 6
`define ACS_B_PRESC 5
`define ACS_B_ODD 4
`define ACS_B_DR 3
// status fields
`define ACS_S_RIE 3
`define ACS_S_TIE 0
// extension fields
`define ACS_E_UNITY 0
`define ACS_E_BRG 1
`define ACS_E_CTSOFF 2
`define ACS_E_DCDOFF 3
`define ACS_E_BRK 7
// external clock select code; reset values
`define ACS_CS_EXT 3'h7
`define ACS_CTRL_A_RST 8'h00
`define ACS_CTRL_B_RST 8'h07
// divider counts, minus one; fifo depth
`define ACS_PRE10_M1 5'h09
`define ACS_PRE30_M1 5'h1D
`define ACS_DIV16_M1 6'h0F
`define ACS_DIV64_M1 6'h3F
`define ACS_HALF16_M1 6'h07
`define ACS_HALF64_M1 6'h1F
`define ACS_FIFO_DEPTH 3'h4
`endif

// File: design/acs_channel.v
// acs_channel.v: one async serial channel (control, status, baud, tx, rx fifo)
// assumes Avalon-MM master on sys_clk; serial pins are asynchronous and synced.
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`include "acs_map.vh"
module acs_channel #(
  parameter CHAN = 0
) (
  input wire sys_clk,
  input wire rstn,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire rx_in,
  output reg tx_out,
  output reg request_to_send_out,
  input wire clear_to_send_in,
  input wire carrier_detect,
  input wire async_ext_clock_pin,
  input wire cts_func_en,
  input wire dcd_func_en,
  input wire io_halt_mode,
  input wire [1:0] dma_src_mode,
  input wire [1:0] dma_src_upper,
  input wire dma1_direction,
  input wire [1:0] dma1_io_upper,
  output reg irq_out
);
  reg [7:0] ctrl_a_reg, ctrl_b_reg, tx_hold_reg;
  reg unity_reg, brg_reg, cts_off_reg, dcd_off_reg, rie_reg, tie_reg;
  reg hold_full_reg, ovr_reg, pe_reg, fe_reg, brk_reg, ovr_pend_reg, dcd_stat_reg;
  reg dcd_fell_reg, head_new_reg, rx_addr_reg;
  reg [1:0] rx_s, cts_s;
  reg [2:0] dcd_s, ck_s;
  // synchronisers; stage 0 is read only by stage 1
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_s <= 2'h3;
      cts_s <= 2'h0;
      dcd_s <= 3'h0;
      ck_s <= 3'h0;
    end else begin
      rx_s <= {rx_s[0], rx_in};
      cts_s <= {cts_s[0], clear_to_send_in};
      dcd_s <= {dcd_s[1:0], carrier_detect};
      ck_s <= {ck_s[1:0], async_ext_clock_pin};
    end
  end
  wire rx_pin = rx_s[1];
  wire cts_pin = cts_s[1];
  wire dcd_pin = dcd_s[1];
  wire dcd_prev = dcd_s[2];
  wire cts_hold = (CHAN == 0) && cts_func_en && !cts_off_reg && cts_pin;
  wire dcd_hold = (CHAN == 0) && dcd_func_en && !dcd_off_reg && dcd_pin;
  wire rx_kill = io_halt_mode || dcd_hold;
  // bus: one wait cycle, then the access completes
  wire req = avs_read || avs_write;
  wire acc = req && !avs_waitrequest;
  wire wr = acc && avs_write && avs_byteenable[0];
  wire rd = acc && avs_read;
  wire [7:0] wd = avs_writedata[7:0];
  wire [2:0] fmt = ctrl_a_reg[2:0];
  wire mdrop = ctrl_b_reg[`ACS_B_MDROP];
  wire nd8 = fmt[2];
  wire par_en = fmt[1] && !mdrop;
  wire has_ex = par_en || mdrop;
  wire two_stop = fmt[0];
  wire odd = ctrl_b_reg[`ACS_B_ODD];
  wire [2:0] cs = ctrl_b_reg[2:0];
  wire ext_ck = (cs == `ACS_CS_EXT);
  // baud generation
  reg [4:0] pre_cnt_reg;
  reg [5:0] pow_cnt_reg, samp_cnt_reg;
  reg presc_reg;
  wire [4:0] pre_m1 = presc_reg ? `ACS_PRE30_M1 : `ACS_PRE10_M1;
  wire pre_wrap = (pre_cnt_reg == pre_m1);
  wire [5:0] pow_mask = (6'h01 << cs) - 6'h01;
  wire [5:0] div_m1 = unity_reg ? 6'h00 : (ctrl_b_reg[`ACS_B_DR] ? `ACS_DIV64_M1 : `ACS_DIV16_M1);
  wire [5:0] half_m1 = unity_reg ? 6'h00 :
    (ctrl_b_reg[`ACS_B_DR] ? `ACS_HALF64_M1 : `ACS_HALF16_M1);
  // external clock edges; system clock power-of-two chain
  wire samp_tick = ext_ck ? (ck_s[1] && !ck_s[2]) :
    (pre_wrap && ((pow_cnt_reg & pow_mask) == pow_mask));
  wire bit_tick = samp_tick && (samp_cnt_reg == div_m1);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt_reg <= 5'h00;
      pow_cnt_reg <= 6'h00;
      samp_cnt_reg <= 6'h00;
    end else begin
      pre_cnt_reg <= pre_wrap ? 5'h00 : pre_cnt_reg + 5'h01;
      if (pre_wrap)
        pow_cnt_reg <= pow_cnt_reg + 6'h01;
      if (samp_tick)
        samp_cnt_reg <= (samp_cnt_reg >= div_m1) ? 6'h00 : samp_cnt_reg + 6'h01;
    end
  end
  // receive fifo, entry = {brk, fe, pe, data}
  reg [10:0] fifo_mem [0:3];
  reg [1:0] rd_ptr_reg, wr_ptr_reg;
  reg [2:0] cnt_reg;
  wire [10:0] head = fifo_mem[rd_ptr_reg];
  wire rx_full = (cnt_reg != 3'h0);
  wire fifo_full = (cnt_reg == `ACS_FIFO_DEPTH);
  wire pop = rd && (avs_address == `ACS_RX_DATA) && rx_full;
  // receiver
  reg rx_busy_reg;
  reg [5:0] rx_cnt_reg;
  reg [3:0] rx_idx_reg;
  reg [7:0] rx_byte_reg;
  reg rx_ex_reg;
  wire [3:0] nd = nd8 ? 4'h8 : 4'h7;
  wire [3:0] stop_idx = nd + {3'h0, has_ex} + 4'h1;
  wire rx_en = ctrl_a_reg[`ACS_A_RXON] && !rx_kill;
  wire smp = rx_busy_reg && samp_tick && (rx_cnt_reg == 6'h00);
  wire done = smp && (rx_idx_reg == stop_idx);
  wire c_fe = !rx_pin;
  wire c_pe = par_en && ((^rx_byte_reg ^ rx_ex_reg) != odd);
  wire c_brk = c_fe && (rx_byte_reg == 8'h00);
  wire wanted = !(mdrop && ctrl_a_reg[`ACS_A_WAKE] && !rx_ex_reg);
  // drop while full or while overrun is pending or flagged
  wire blocked = fifo_full || ovr_pend_reg || ovr_reg;
  wire push = done && wanted && !blocked;
  wire drop = done && wanted && blocked;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 6'h00;
      rx_idx_reg <= 4'h0;
      rx_byte_reg <= 8'h00;
      rx_ex_reg <= 1'b0;
      rx_addr_reg <= 1'b0;
    end else if (!rx_en) begin
      rx_busy_reg <= 1'b0;
    end else if (!rx_busy_reg) begin
      if (samp_tick && !rx_pin) begin
        rx_busy_reg <= 1'b1;
        rx_cnt_reg <= half_m1;
        rx_idx_reg <= unity_reg ? 4'h1 : 4'h0;
        rx_byte_reg <= 8'h00;
        rx_ex_reg <= 1'b1;
      end
    end else if (samp_tick) begin
      if (rx_cnt_reg != 6'h00) begin
        rx_cnt_reg <= rx_cnt_reg - 6'h01;
      end else begin
        rx_cnt_reg <= div_m1;
        rx_idx_reg <= rx_idx_reg + 4'h1;
        if (rx_idx_reg == 4'h0 && rx_pin)
          rx_busy_reg <= 1'b0;
        else if (rx_idx_reg != 4'h0 && rx_idx_reg <= nd)
          rx_byte_reg[rx_idx_reg[2:0] - 3'h1] <= rx_pin;
        else if (has_ex && rx_idx_reg == nd + 4'h1)
          rx_ex_reg <= rx_pin;
        if (done) begin
          rx_busy_reg <= 1'b0;
          rx_addr_reg <= rx_ex_reg;
        end
      end
    end
  end
  always @(posedge sys_clk) begin
    if (push)
      fifo_mem[wr_ptr_reg] <= {c_brk, c_fe, c_pe, rx_byte_reg};
  end
  wire error_flag_reset = wr && (avs_address == `ACS_CTRL_A) && !wd[`ACS_A_ADDR];
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr_reg <= 2'h0;
      wr_ptr_reg <= 2'h0;
      cnt_reg <= 3'h0;
      head_new_reg <= 1'b0;
      ovr_pend_reg <= 1'b0;
      ovr_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else if (rx_kill) begin
      // halt or carrier hold empties fifo and clears flags
      rd_ptr_reg <= 2'h0;
      wr_ptr_reg <= 2'h0;
      cnt_reg <= 3'h0;
      head_new_reg <= 1'b0;
      ovr_pend_reg <= 1'b0;
      ovr_reg <= 1'b0;
      pe_reg <= 1'b0;
      fe_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 2'h1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      // full flag follows occupancy, clears when read empty
      cnt_reg <= cnt_reg + {2'h0, push} - {2'h0, pop};
      head_new_reg <= (push && cnt_reg == 3'h0) || (pop && (cnt_reg > 3'h1 || push));
      if (drop)
        ovr_pend_reg <= 1'b1;
      else if (ovr_pend_reg && cnt_reg <= 3'h1)
        ovr_pend_reg <= 1'b0;
      // errors set wins over software reset
      if (ovr_pend_reg && cnt_reg <= 3'h1)
        ovr_reg <= 1'b1;
      else if (error_flag_reset)
        ovr_reg <= 1'b0;
      // error flags raise when the character is at head
      if (head_new_reg && head[8])
        pe_reg <= 1'b1;
      else if (error_flag_reset)
        pe_reg <= 1'b0;
      if (head_new_reg && head[9])
        fe_reg <= 1'b1;
      else if (error_flag_reset)
        fe_reg <= 1'b0;
      if (head_new_reg && head[10])
        brk_reg <= 1'b1;
      else if (error_flag_reset)
        brk_reg <= 1'b0;
    end
  end
  reg tx_busy_reg;
  reg [10:0] tx_sh_reg;
  reg [3:0] tx_left_reg;
  wire tx_on = ctrl_a_reg[`ACS_A_TXON];
  // address bit from control b; unused slot idles high
  wire exb = mdrop ? ctrl_b_reg[`ACS_B_TXADDR] : (par_en ? (^tx_hold_reg[6:0] ^
    (nd8 & tx_hold_reg[7]) ^ odd) : 1'b1);
  wire [9:0] body = nd8 ? {1'b1, exb, tx_hold_reg} : {2'b11, exb, tx_hold_reg[6:0]};
  // every stop bit shifts while busy, so a back-to-back load keeps them
  wire [3:0] tx_len = stop_idx + {3'h0, two_stop} + 4'h1;
  wire tx_load = tx_on && !tx_busy_reg && hold_full_reg && !cts_hold && bit_tick;
  wire hold_wr = wr && (avs_address == `ACS_TX_HOLD);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_busy_reg <= 1'b0;
      tx_sh_reg <= 11'h7FF;
      tx_left_reg <= 4'h0;
      tx_out <= 1'b1;
      hold_full_reg <= 1'b0;
    end else begin
      // write clears empty, transfer or halt sets it
      if (io_halt_mode)
        hold_full_reg <= 1'b0;
      else if (hold_wr)
        hold_full_reg <= 1'b1;
      else if (tx_load)
        hold_full_reg <= 1'b0;
      if (!tx_on || io_halt_mode) begin
        tx_busy_reg <= 1'b0;
        tx_out <= 1'b1;
      end else if (tx_load) begin
        tx_busy_reg <= 1'b1;
        tx_sh_reg <= {body, 1'b0};
        tx_left_reg <= tx_len;
      end else if (tx_busy_reg && bit_tick) begin
        tx_out <= tx_sh_reg[0];
        tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
        if (tx_left_reg == 4'h1)
          tx_busy_reg <= 1'b0;
      end else if (!tx_busy_reg && bit_tick) begin
        tx_out <= 1'b1;
      end
    end
  end
  wire tx_empty_flag = !hold_full_reg && !cts_hold;
  // registers and carrier status
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_reg <= `ACS_CTRL_A_RST;
      ctrl_b_reg <= `ACS_CTRL_B_RST;
      tx_hold_reg <= 8'h00;
      presc_reg <= 1'b0;
      unity_reg <= 1'b0;
      brg_reg <= 1'b0;
      cts_off_reg <= 1'b0;
      dcd_off_reg <= 1'b0;
      rie_reg <= 1'b0;
      tie_reg <= 1'b0;
      dcd_stat_reg <= 1'b0;
      dcd_fell_reg <= 1'b0;
    end else begin
      if (wr && avs_address == `ACS_CTRL_A)
        ctrl_a_reg <= wd;
      if (wr && avs_address == `ACS_CTRL_B) begin
        ctrl_b_reg <= wd;
        // prescale only with internal clock and baud mode 0
        if (!ext_ck && !brg_reg)
          presc_reg <= wd[`ACS_B_PRESC];
      end
      if (hold_wr)
        tx_hold_reg <= wd;
      if (wr && avs_address == `ACS_STATUS) begin
        rie_reg <= wd[`ACS_S_RIE];
        tie_reg <= wd[`ACS_S_TIE];
      end
      if (wr && avs_address == `ACS_EXT) begin
        unity_reg <= wd[`ACS_E_UNITY];
        brg_reg <= wd[`ACS_E_BRG];
        cts_off_reg <= wd[`ACS_E_CTSOFF];
        dcd_off_reg <= wd[`ACS_E_DCDOFF];
      end
      // halt forces tx_on and rx_on off
      if (io_halt_mode) begin
        ctrl_a_reg[`ACS_A_TXON] <= 1'b0;
        ctrl_a_reg[`ACS_A_RXON] <= 1'b0;
      end
      // set while high, read after fall clears
      if (CHAN == 0 && dcd_func_en && dcd_pin) begin
        dcd_stat_reg <= 1'b1;
        dcd_fell_reg <= 1'b0;
      end else if (rd && avs_address == `ACS_STATUS && dcd_fell_reg) begin
        dcd_stat_reg <= 1'b0;
        dcd_fell_reg <= 1'b0;
      end else if (dcd_prev && !dcd_pin) begin
        dcd_fell_reg <= 1'b1;
      end
    end
  end
  reg [7:0] rmux;
  always @* begin
    rmux = 8'h00;
    case (avs_address)
      `ACS_CTRL_A: rmux = {ctrl_a_reg[7:5], (CHAN == 0) & ctrl_a_reg[4], rx_addr_reg, fmt};
      `ACS_CTRL_B: rmux = {ctrl_b_reg[7:6], (CHAN == 0) & cts_func_en & cts_pin,
        ctrl_b_reg[4:0]};
      `ACS_STATUS: rmux = {rx_full, ovr_reg, pe_reg, fe_reg, rie_reg,
        dcd_stat_reg, tx_empty_flag, tie_reg};
      `ACS_TX_HOLD: rmux = tx_hold_reg;
      `ACS_RX_DATA: rmux = rx_full ? head[7:0] : 8'h00;
      `ACS_EXT: rmux = {brk_reg, 3'h0, dcd_off_reg, cts_off_reg, brg_reg, unity_reg};
      default: rmux = 8'h00;
    endcase
  end
  // dma routing masks the full request
  wire dma_rx = (dma_src_mode == 2'h3 && dma_src_upper == 2'h2) ||
    (dma1_direction && dma1_io_upper == 2'h2);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      request_to_send_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest)
        avs_readdata <= {24'h000000, rmux};
      request_to_send_out <= (CHAN == 0) && ctrl_a_reg[`ACS_A_RTS];
      irq_out <= (rie_reg && ((rx_full && !dma_rx) || ovr_reg || pe_reg || fe_reg ||
        (CHAN == 0 && dcd_stat_reg))) || (tie_reg && tx_empty_flag);
    end
  end
endmodule // acs_channel

// File: verification/acs_chk_chk.sv
// acs_chk_chk.sv: port assertions for one async serial channel
// assumes it is bound to acs_channel and sees only its ports
`timescale 1ns/10ps
module acs_chk #(
  parameter CHAN = 0
) (
  input wire sys_clk,
  input wire rstn,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire tx_out,
  input wire request_to_send_out,
  input wire clear_to_send_in,
  input wire cts_func_en,
  input wire io_halt_mode,
  input wire irq_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire done = !avs_waitrequest && (avs_read || avs_write);
  wire wr_a = done && avs_write && avs_address == 3'h0 && avs_byteenable[0];
  wire rd_st = done && avs_read && avs_address == 3'h2;
  reg rts_exp;
  reg cts_off;
  // write data is released after the accepting edge, so keep it
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rts_exp <= 1'b0;
      cts_off <= 1'b0;
    end else begin
      if (wr_a)
        rts_exp <= (CHAN == 0) ? avs_writedata[4] : 1'b0;
      // extension write may switch the clear-to-send hold off
      if (done && avs_write && avs_address == 3'h5 && avs_byteenable[0])
        cts_off <= avs_writedata[2];
    end
  end
  sequence s_cts_calm;
    $stable(clear_to_send_in) [*6];
  endsequence
  sequence s_halt_held;
    io_halt_mode [*4];
  endsequence
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after a request");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rts_follow: assert property (wr_a |=> ##1 request_to_send_out == rts_exp)
    else $error("request_to_send_out does not follow control write");
  a_rts_hold: assert property (!wr_a && !$past(wr_a) |=> $stable(request_to_send_out))
    else $error("request_to_send_out changed without a control write");
  a_tx_abort: assert property (wr_a && !avs_writedata[5] |-> ##[1:3] tx_out [*8])
    else $error("transmit line not idle after transmitter off");
  a_cts_read: assert property (s_cts_calm ##0 (done && avs_read && avs_address == 3'h1
    && cts_func_en) |-> avs_readdata[5] == (CHAN == 0 && clear_to_send_in))
    else $error("clear to send level misread");
  a_cts_hold: assert property (s_cts_calm ##0 (rd_st && cts_func_en && clear_to_send_in
    && !cts_off && CHAN == 0) |-> !avs_readdata[1])
    else $error("tx empty not held off by clear to send");
  a_halt_state: assert property (s_halt_held ##0 (rd_st && !clear_to_send_in)
    |-> avs_readdata[1] && !avs_readdata[7])
    else $error("halt did not set tx empty and clear rx full");
  a_tx_irq: assert property (rd_st && avs_readdata[1] && avs_readdata[0] |-> ##[0:2] irq_out)
    else $error("no interrupt with tx empty and enable");
  a_unmapped_zero: assert property (done && avs_read && avs_address[2:1] == 2'h3
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // acs_chk
bind acs_channel acs_chk #(.CHAN(CHAN)) i_acs_chk (.sys_clk(sys_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tx_out(tx_out),
  .request_to_send_out(request_to_send_out), .clear_to_send_in(clear_to_send_in),
  .cts_func_en(cts_func_en), .io_halt_mode(io_halt_mode), .irq_out(irq_out));

// File: verification/acs_peer.sv
// acs_peer.sv: remote serial transceiver on the channel's line
// assumes sample tick sys_clk/10 and 16 samples per bit, so BIT_CYC cycles a bit
`timescale 1ns/10ps
module acs_peer #(
  parameter BIT_CYC = 160
) (
  input wire sys_clk,
  input wire tx_out,
  input wire [3:0] frame_len,
  output reg rx_in = 1'b1,
  output reg [11:0] cap_bits,
  output reg [7:0] cap_count
);
  integer i;
  task send(input [7:0] d, input integer nd, input ex_en, input ex, input stop_v);
    integer k;
    begin
      // start, data lsb first, extra bit
      rx_in <= 1'b0;
      repeat (BIT_CYC) @(posedge sys_clk);
      for (k = 0; k < nd; k = k + 1) begin
        rx_in <= d[k];
        repeat (BIT_CYC) @(posedge sys_clk);
      end
      if (ex_en) begin
        rx_in <= ex;
        repeat (BIT_CYC) @(posedge sys_clk);
      end
      rx_in <= stop_v;
      repeat (BIT_CYC) @(posedge sys_clk);
      // idle bit so the next start edge is clean
      rx_in <= 1'b1;
      repeat (BIT_CYC) @(posedge sys_clk);
    end
  endtask
  initial begin
    cap_bits = 12'h000;
    cap_count = 8'h00;
    forever begin
      @(negedge tx_out);
      repeat (BIT_CYC / 2) @(posedge sys_clk);
      cap_bits = 12'h000;
      for (i = 0; i < frame_len; i = i + 1) begin
        repeat (BIT_CYC) @(posedge sys_clk);
        cap_bits[i] = tx_out;
      end
      cap_count = cap_count + 8'h01;
    end
  end
endmodule // acs_peer

// File: verification/test_async_serial_channel_control.sv
// test_async_serial_channel_control.sv: register and serial tests of channel 0
// assumes acs_peer on the serial pins and the register map header
`timescale 1ns/10ps
`include "acs_map.vh"
module test_async_serial_channel_control;
  localparam [95:0] TXT = {8'h22, 8'h00, 8'h5A, 8'h26, 8'hC0, 8'h3C,
    8'h23, 8'h10, 8'h55, 8'h24, 8'h00, 8'hA5};
  localparam [39:0] RXD = {8'h55, 8'h44, 8'h33, 8'h22, 8'h11};
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg [2:0] avs_address = 3'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg [3:0] avs_byteenable = 4'hF;
  reg cts_pin = 1'b0;
  reg cts_en = 1'b1;
  reg halt = 1'b0;
  reg [1:0] dsm = 2'h0;
  reg [1:0] dsu = 2'h0;
  reg dim = 1'b0;
  reg [1:0] diu = 2'h0;
  reg [3:0] frame_len = 4'h9;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, rx_in, tx_out, rts, irq;
  wire [11:0] cap_bits;
  wire [7:0] cap_count;
  reg [31:0] rd;
  reg [23:0] ent;
  reg [15:0] ef;
  integer bad_count = 0;
  integer check_count = 0;
  integer n, t;
  acs_channel #(.CHAN(0)) i_acs_channel (.sys_clk(sys_clk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_in(rx_in),
    .tx_out(tx_out), .request_to_send_out(rts), .clear_to_send_in(cts_pin),
    .carrier_detect(1'b0), .async_ext_clock_pin(1'b0), .cts_func_en(cts_en),
    .dcd_func_en(1'b0), .io_halt_mode(halt), .dma_src_mode(dsm), .dma_src_upper(dsu),
    .dma1_direction(dim), .dma1_io_upper(diu), .irq_out(irq));
  acs_peer #(.BIT_CYC(160)) i_acs_peer (.sys_clk(sys_clk), .tx_out(tx_out),
    .frame_len(frame_len), .rx_in(rx_in), .cap_bits(cap_bits), .cap_count(cap_count));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [8*16:1] name, input [31:0] exp, input [31:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // one access; hold until waitrequest samples low, then release
  task bus(input wr, input [2:0] a, input [7:0] d);
    integer k;
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= !wr;
      k = 0;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && k < 20) begin
        @(posedge sys_clk);
        k = k + 1;
      end
      if (k >= 20) begin
        chk("bus_timeout", 32'h0, 32'h1);
        stop_test;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task rdc(input [2:0] a, input [7:0] exp, input [8*16:1] name);
    begin
      bus(1'b0, a, 8'h00);
      chk(name, {24'h0, exp}, rd);
    end
  endtask
  task wait_frame(input integer old);
    integer k;
    begin
      k = 0;
      while (cap_count == old && k < 4000) begin
        @(posedge sys_clk);
        k = k + 1;
      end
      if (k >= 4000) begin
        chk("frame_wait", 32'h0, 32'h1);
        stop_test;
      end
    end
  endtask
  function [15:0] frame(input [7:0] ca, input [7:0] cb, input [7:0] d);
    reg [11:0] b;
    integer p;
    begin
      p = ca[2] ? 8 : 7;
      b = {4'h0, ca[2] ? d : {1'b0, d[6:0]}};
      if (cb[6]) begin
        b[p] = cb[7];
        p = p + 1;
      end else if (ca[1]) begin
        b[p] = ^b[7:0] ^ cb[4];
        p = p + 1;
      end
      b[p] = 1'b1;
      b[p + 1] = ca[0];
      p = p + 1 + ca[0];
      frame = {p[3:0], b};
    end
  endfunction
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    rdc(`ACS_CTRL_A, 8'h00, "ctrl_a_rst");
    rdc(`ACS_CTRL_B, 8'h07, "ctrl_b_rst");
    rdc(`ACS_STATUS, 8'h02, "status_rst");
    bus(1'b1, 3'h6, 8'hFF);
    rdc(3'h6, 8'h00, "unmapped");
    avs_byteenable <= 4'h0;
    bus(1'b1, `ACS_STATUS, 8'h01);
    avs_byteenable <= 4'hF;
    rdc(`ACS_STATUS, 8'h02, "be_ignored");
    $display("reset test done");
    bus(1'b1, `ACS_CTRL_B, 8'h00);
    for (n = 0; n < 4; n = n + 1) begin
      ent = TXT[n * 24 +: 24];
      ef = frame(ent[23:16], ent[15:8], ent[7:0]);
      frame_len <= ef[15:12];
      bus(1'b1, `ACS_CTRL_B, ent[15:8]);
      bus(1'b1, `ACS_CTRL_A, ent[23:16]);
      t = cap_count;
      bus(1'b1, `ACS_TX_HOLD, ent[7:0]);
      wait_frame(t);
      chk("tx_frame", {20'h0, ef[11:0]}, {20'h0, cap_bits});
      repeat (200) @(posedge sys_clk);
    end
    $display("transmit format test done");
    bus(1'b1, `ACS_CTRL_A, 8'h24);
    bus(1'b1, `ACS_TX_HOLD, 8'h00);
    repeat (400) @(posedge sys_clk);
    bus(1'b1, `ACS_CTRL_A, 8'h14);
    rdc(`ACS_STATUS, 8'h02, "tx_empty_kept");
    chk("rts_out", 32'h1, {31'h0, rts});
    cts_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rdc(`ACS_CTRL_B, 8'h20, "cts_level");
    rdc(`ACS_STATUS, 8'h00, "cts_hold");
    cts_pin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    bus(1'b1, `ACS_STATUS, 8'h01);
    rdc(`ACS_STATUS, 8'h03, "tx_irq_en");
    chk("tx_irq", 32'h1, {31'h0, irq});
    bus(1'b1, `ACS_STATUS, 8'h00);
    $display("transmit control test done");
    bus(1'b1, `ACS_CTRL_A, 8'h44);
    for (n = 0; n < 5; n = n + 1)
      i_acs_peer.send(RXD[n * 8 +: 8], 8, 1'b0, 1'b0, n != 2);
    rdc(`ACS_STATUS, 8'h82, "rx_full");
    rdc(`ACS_RX_DATA, 8'h11, "fifo_0");
    rdc(`ACS_RX_DATA, 8'h22, "fifo_1");
    rdc(`ACS_STATUS, 8'h92, "framing_err");
    rdc(`ACS_RX_DATA, 8'h33, "fifo_2");
    rdc(`ACS_STATUS, 8'hD2, "overrun");
    rdc(`ACS_RX_DATA, 8'h44, "fifo_3");
    rdc(`ACS_RX_DATA, 8'h00, "fifo_empty");
    rdc(`ACS_STATUS, 8'h52, "rx_drained");
    bus(1'b1, `ACS_CTRL_A, 8'h44);
    rdc(`ACS_STATUS, 8'h02, "err_reset");
    $display("receive fifo test done");
    bus(1'b1, `ACS_CTRL_B, 8'h40);
    bus(1'b1, `ACS_CTRL_A, 8'hC4);
    i_acs_peer.send(8'h66, 8, 1'b1, 1'b0, 1'b1);
    rdc(`ACS_STATUS, 8'h02, "wake_skip");
    i_acs_peer.send(8'h77, 8, 1'b1, 1'b1, 1'b1);
    rdc(`ACS_STATUS, 8'h82, "wake_take");
    rdc(`ACS_CTRL_A, 8'hCC, "rx_addr_bit");
    bus(1'b1, `ACS_STATUS, 8'h08);
    repeat (3) @(posedge sys_clk);
    chk("rx_irq", 32'h1, {31'h0, irq});
    dsm <= 2'h3;
    dsu <= 2'h2;
    repeat (3) @(posedge sys_clk);
    chk("rx_irq_dma", 32'h0, {31'h0, irq});
    dsm <= 2'h0;
    dim <= 1'b1;
    diu <= 2'h2;
    repeat (3) @(posedge sys_clk);
    chk("rx_irq_dma1", 32'h0, {31'h0, irq});
    halt <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rdc(`ACS_STATUS, 8'h0A, "halt_status");
    bus(1'b0, `ACS_CTRL_A, 8'h00);
    chk("halt_enables", 32'h0, rd & 32'h60);
    halt <= 1'b0;
    $display("wake and halt test done");
    stop_test;
  end
endmodule // test_async_serial_channel_control
